/* File: src/sync_serial_slave_sleep.v */
/*
  synchronous slave serial unit: shift registers clocked by the external
  master's clock pin (sampled and edge-detected on clk), two-deep receive
  fifo, buffered transmit, wake-up and interrupt request toward the cpu.
  assumes: clk keeps running in sleep (it models the external clock path),
  the master's clock is far slower than clk, register port per house bus.
*/
`timescale 1ns/10ps
`include "sync_slave_regs.vh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// [R1] slave receive: continuous enable keeps receiver always active, never idle
// [R2] single-receive enable ignored in slave mode
// [R3] character arriving in sleep moves from shift register into receive fifo
// [R4] receive flag with enable wakes the cpu to the next instruction
// [R5] after wake with global enable, branch to vector 004h
// [R6] software sets sync and port enable, clears clock source and analog
// [R7] receive flag sets at completion; request only if receive enable set
// [R8] software reads ninth bit first, then the low 8 bits
// [R9] clearing continuous enable or port enable clears overrun; port resets unit
// [R10] in sleep only synchronous slave mode keeps shifting
// [R11] shift registers clocked only by the master's clock pin
// [R12] software drains receive buffer before sleep to clear the flag
// [R13] in sleep full word clocked in sets receive flag and wakes cpu
// [R14] software fills shift register and buffer before sleep
// [R15] software sets transmit and peripheral enables before sleep
// [R16] word shifted out: buffered byte loads, transmit flag sets, wakes cpu
// [R17] buffer then accepts a new byte; writing it clears transmit flag
// [R18] slave transmit takes clock pin edges and drives data pin
// [R19] pin locations relocatable through pin select, defined reset default
// [R20] two-entry fifo; third character sets overrun, keeps data, blocks receive
// [R21] nine-bit receive shifts nine bits; ninth bit of oldest character
// [R22] slave selected by sync, no clock source, port enable; receive enables pick
// [R23] two writes before sleep: first shifts, second waits, flag stays clear
// [R24] transmit changes on one clock edge, receive samples on the opposite
module sync_serial_slave_sleep (
  input  wire       clk,
  input  wire       srst,
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       sleeping,
  input  wire [1:0] alternate_pin_select,
  output reg  [1:0] pin_location,
  input  wire       clock_pin,
  input  wire       data_pin_in,
  output reg        data_pin_out,
  output reg        data_pin_oe_n,
  output reg        wake,
  output reg        irq_request,
  output reg [11:0] irq_vector
);

  reg [7:0] rx_status;
  reg [7:0] tx_status;
  reg [7:0] baud_control_reg;
  reg [7:0] interrupt_control;
  reg [7:0] peripheral_irq_enable_one;
  reg       receive_irq_flag;
  reg       transmit_irq_flag;
  reg [8:0] fifo [0:1];
  reg       fifo_head;
  reg [1:0] fifo_count;
  reg       overrun_error_flag;
  reg [8:0] receive_shift_register;
  reg [3:0] rx_bits;
  reg [8:0] transmit_shift_register;
  reg [3:0] tx_bits;
  reg       tsr_full;
  reg [8:0] transmit_data_buffer;
  reg       txbuf_full;
  reg       ck_s1;
  reg       ck_s2;
  reg       ck_prev;
  reg       dt_s1;
  reg       dt_s2;

  wire [7:0] peripheral_irq_flags_one;
  wire       serial_port_enable;
  wire       continuous_receive_enable;
  wire       nine_bit_receive_select;
  wire       nine_bit_transmit_select;
  wire       clock_polarity_select;
  wire       slave_mode;
  wire       receiving;
  wire       transmitting;
  wire       ck_rise;
  wire       ck_fall;
  wire       shift_edge;
  wire       sample_edge;
  wire [3:0] rx_len;
  wire [3:0] tx_len;
  wire       rx_done;
  wire       tx_done;
  wire       rx_read;
  wire       tx_write;
  wire       fifo_push;
  wire [8:0] rx_word;
  wire [8:0] fifo_top;
  wire       rx_event;
  wire       tx_event;
  wire       pending;

  //////////////////////////////////////////////////////////////////////////
  // configuration decode

  // character length in bits, nine when the ninth bit is selected
  function [3:0] char_len;
    input nine;
    begin
      char_len = nine ? 4'h9 : 4'h8;
    end
  endfunction

  assign serial_port_enable        = rx_status[`RS_SERIAL_PORT_ENABLE_BIT];
  assign continuous_receive_enable = rx_status[`RS_CONTINUOUS_RECEIVE_ENABLE_BIT];
  assign nine_bit_receive_select   = rx_status[`RS_RX9_BIT];
  assign nine_bit_transmit_select  = tx_status[`TS_TX9_BIT];
  assign clock_polarity_select     = baud_control_reg[`BC_CLOCK_POLARITY_SELECT_BIT];
  // master mode is not built, so it never shifts, awake or asleep
  assign slave_mode = serial_port_enable & tx_status[`TS_SYNC_BIT] &
                      ~tx_status[`TS_CLOCK_SOURCE_SELECT_BIT];   // see [R22] see [R10]
  // single-receive enable takes no part in receiving; set, it blocks transmit
  assign receiving    = slave_mode & continuous_receive_enable; // see [R1] see [R2]
  assign transmitting = slave_mode & ~continuous_receive_enable &
                        ~rx_status[`RS_SINGLE_RECEIVE_ENABLE_BIT];  // see [R22]

  assign peripheral_irq_flags_one = {2'h0, receive_irq_flag,
                                     transmit_irq_flag, 4'h0};

  //////////////////////////////////////////////////////////////////////////
  // external clock: synchronise, then find edges

  always @(posedge clk) begin
    if (srst) begin
      ck_s1   <= 1'b0;
      ck_s2   <= 1'b0;
      ck_prev <= 1'b0;
      dt_s1   <= 1'b0;
      dt_s2   <= 1'b0;
    end else begin
      ck_s1   <= clock_pin;
      ck_s2   <= ck_s1;
      ck_prev <= ck_s2;
      dt_s1   <= data_pin_in;
      dt_s2   <= dt_s1;
    end
  end

  assign ck_rise = ck_s2 & ~ck_prev;
  assign ck_fall = ~ck_s2 & ck_prev;
  // idle-low clock: drive on rising, sample on falling; inverted if set
  assign shift_edge  = clock_polarity_select ? ck_fall : ck_rise; // see [R24]
  assign sample_edge = clock_polarity_select ? ck_rise : ck_fall; // see [R24]

  assign rx_len   = char_len(nine_bit_receive_select);  // see [R21]
  assign tx_len   = char_len(nine_bit_transmit_select);
  assign rx_word  = receive_shift_register;
  // overrun blocks further characters
  assign rx_done  = receiving & sample_edge & ~overrun_error_flag &
                    (rx_bits == rx_len - 4'h1);          // see [R11] see [R20]
  assign tx_done  = transmitting & tsr_full & shift_edge &
                    (tx_bits == tx_len);                 // see [R11]
  assign rx_read  = rd & (addr == `OFS_RX_DATA);
  assign tx_write = wr & (addr == `OFS_TX_DATA);
  assign fifo_push = rx_done & (fifo_count != `RX_FIFO_DEPTH);
  assign fifo_top  = fifo[fifo_head];

  //////////////////////////////////////////////////////////////////////////
  // receive path

  always @(posedge clk) begin
    if (srst | ~serial_port_enable) begin  // see [R9]
      rx_bits                <= 4'h0;
      receive_shift_register <= 9'h000;
      fifo_head              <= 1'b0;
      fifo_count             <= 2'h0;
      overrun_error_flag     <= 1'b0;
      fifo[0]                <= 9'h000;
      fifo[1]                <= 9'h000;
    end else begin
      if (~receiving) begin
        rx_bits <= 4'h0;
      end else if (sample_edge & ~overrun_error_flag) begin // see [R11]
        // lsb first: bits enter at the top of the character width
        if (nine_bit_receive_select) begin
          receive_shift_register <= {dt_s2, receive_shift_register[8:1]};
        end else begin
          receive_shift_register <= {1'b0, dt_s2,
                                     receive_shift_register[7:1]};
        end
        rx_bits <= rx_done ? 4'h0 : rx_bits + 4'h1;
      end
      // clearing continuous enable clears the overrun
      if (~continuous_receive_enable) begin
        overrun_error_flag <= 1'b0;  // see [R9]
      end else if (rx_done & (fifo_count == `RX_FIFO_DEPTH) & ~rx_read) begin
        overrun_error_flag <= 1'b1;  // see [R20]
      end
      if (fifo_push) begin  // see [R3] see [R13]
        if (nine_bit_receive_select) begin
          fifo[fifo_head ^ fifo_count[0]] <= {dt_s2,
                                              receive_shift_register[8:1]};
        end else begin
          fifo[fifo_head ^ fifo_count[0]] <= {1'b0, dt_s2,
                                              receive_shift_register[7:1]};
        end
      end
      if (rx_read & (fifo_count != 2'h0)) begin
        fifo_head <= ~fifo_head;
      end
      fifo_count <= fifo_count + {1'b0, fifo_push} -
                    {1'b0, rx_read & (fifo_count != 2'h0)};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit path

  always @(posedge clk) begin
    if (srst | ~serial_port_enable) begin
      transmit_shift_register <= 9'h000;
      tx_bits                 <= 4'h0;
      tsr_full                <= 1'b0;
      transmit_data_buffer    <= 9'h000;
      txbuf_full              <= 1'b0;
      data_pin_out            <= 1'b0;
      data_pin_oe_n           <= 1'b1;
    end else begin
      data_pin_oe_n <= ~(transmitting & tx_status[`TS_TXEN_BIT]); // see [R18]
      if (tx_write) begin
        transmit_data_buffer <= {tx_status[`TS_TX9D_BIT], wdata};
      end
      // first write goes straight to the shift register
      if (~tsr_full & (txbuf_full | tx_write)) begin // see [R23]
        transmit_shift_register <= txbuf_full ? transmit_data_buffer :
                                   {tx_status[`TS_TX9D_BIT], wdata};
        tsr_full   <= 1'b1;
        tx_bits    <= 4'h0;
        txbuf_full <= txbuf_full & tx_write;
      end else if (tx_done) begin  // see [R16]
        transmit_shift_register <= transmit_data_buffer;
        tsr_full   <= txbuf_full;
        tx_bits    <= 4'h0;
        txbuf_full <= tx_write;  // see [R17]
      end else begin
        if (tx_write) begin
          txbuf_full <= 1'b1;
        end
        if (transmitting & tsr_full & shift_edge) begin  // see [R18]
          data_pin_out            <= transmit_shift_register[0];
          transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
          tx_bits                 <= tx_bits + 4'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flags, wake and interrupt request

  assign rx_event = fifo_count != 2'h0;
  // flag stays clear while the second word waits
  assign tx_event = ~txbuf_full & ~tx_write;  // see [R23] see [R17]
  assign pending  =
    (receive_irq_flag & peripheral_irq_enable_one[`PF_RCI_BIT]) |
    (transmit_irq_flag & peripheral_irq_enable_one[`PF_TXI_BIT] &
     interrupt_control[`IC_PERIPHERAL_IRQ_ENABLE_BIT]);

  always @(posedge clk) begin
    if (srst) begin
      receive_irq_flag  <= 1'b0;
      transmit_irq_flag <= 1'b0;
      wake              <= 1'b0;
      irq_request       <= 1'b0;
      irq_vector        <= 12'h000;
      pin_location      <= `RST_PINSEL;
    end else begin
      // a push in the read cycle keeps the flag set
      receive_irq_flag  <= rx_event | fifo_push;  // see [R7] see [R13]
      transmit_irq_flag <= tx_event;              // see [R16]
      wake              <= sleeping & pending;     // see [R4] see [R13]
      irq_request       <= pending & interrupt_control[`IC_GIE_BIT]; // see [R5]
      irq_vector        <= `IRQ_VECTOR;            // see [R5]
      pin_location      <= alternate_pin_select;   // see [R19]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register port

  always @(posedge clk) begin
    if (srst) begin
      rx_status                 <= `RST_RX_STATUS;
      tx_status                 <= `RST_TX_STATUS;
      baud_control_reg          <= `RST_BAUD_CTRL;
      interrupt_control         <= `RST_INT_CTRL;
      peripheral_irq_enable_one <= `RST_PIE;
    end else if (wr) begin
      case (addr)
        `OFS_BAUD_CONTROL: begin
          baud_control_reg <= {1'b0, 1'b0, 1'b0, wdata[4], 4'h0};
        end
        `OFS_INTERRUPT_CTRL: begin
          interrupt_control <= wdata;
        end
        `OFS_PERIPH_IRQ_EN: begin
          peripheral_irq_enable_one <= wdata;
        end
        `OFS_RX_STATUS_CTRL: begin
          rx_status <= {wdata[7:2], 2'h0};
        end
        `OFS_TX_STATUS_CTRL: begin
          tx_status <= {wdata[7:2], 1'b0, wdata[0]};
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `OFS_BAUD_CONTROL:   rdata <= baud_control_reg |
                                      {1'b0, ~receiving, 6'h00};
        `OFS_INTERRUPT_CTRL: rdata <= interrupt_control;
        `OFS_PERIPH_IRQ_EN:  rdata <= peripheral_irq_enable_one;
        `OFS_PERIPH_IRQ_FLG: rdata <= peripheral_irq_flags_one;
        // ninth bit of the oldest unread character
        `OFS_RX_STATUS_CTRL: rdata <= {rx_status[7:2], overrun_error_flag,
                                       fifo_top[8]}; // see [R21]
        `OFS_TX_STATUS_CTRL: rdata <= {tx_status[7:2], ~tsr_full,
                                       tx_status[0]};
        `OFS_RX_DATA:        rdata <= fifo_top[7:0];
        default:             rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // sync_serial_slave_sleep

/* File: src/sync_slave_regs.vh */
/*
  register offsets, field positions, reset values for the synchronous
  slave serial unit. assumes inclusion by bare name from the design file.
*/
`ifndef SYNC_SLAVE_REGS_VH
`define SYNC_SLAVE_REGS_VH

// register offsets (3-bit address)
`define OFS_BAUD_CONTROL   3'h0
`define OFS_INTERRUPT_CTRL 3'h1
`define OFS_PERIPH_IRQ_EN  3'h2
`define OFS_PERIPH_IRQ_FLG 3'h3
`define OFS_RX_STATUS_CTRL 3'h4
`define OFS_TX_DATA        3'h5
`define OFS_TX_STATUS_CTRL 3'h6
`define OFS_RX_DATA        3'h7

// receive status/control fields
`define RS_SERIAL_PORT_ENABLE_BIT  7
`define RS_RX9_BIT   6
`define RS_SINGLE_RECEIVE_ENABLE_BIT  5
`define RS_CONTINUOUS_RECEIVE_ENABLE_BIT  4
`define RS_OVERRUN_ERROR_FLAG_BIT  1
`define RS_RECEIVED_NINTH_BIT_BIT  0
// transmit status/control fields
`define TS_CLOCK_SOURCE_SELECT_BIT  7
`define TS_TX9_BIT   6
`define TS_TXEN_BIT  5
`define TS_SYNC_BIT  4
`define TS_TRMT_BIT  1
`define TS_TX9D_BIT  0
// baud control fields
`define BC_RCIDL_BIT 6
`define BC_CLOCK_POLARITY_SELECT_BIT  4
// interrupt control fields
`define IC_GIE_BIT   7
`define IC_PERIPHERAL_IRQ_ENABLE_BIT  6
// peripheral enable / flag fields
`define PF_RCI_BIT   5
`define PF_TXI_BIT   4

// reset values
`define RST_RX_STATUS  8'h00
`define RST_TX_STATUS  8'h02
`define RST_BAUD_CTRL  8'h00
`define RST_INT_CTRL   8'h00
`define RST_PIE        8'h00
`define RST_PINSEL     2'h0

// receive fifo depth and interrupt vector
`define RX_FIFO_DEPTH  2'h2
`define IRQ_VECTOR     12'h004

`endif

/* File: testbench/sync_master_model.sv */
/* external synchronous master: makes the shift clock, drives or reads
   the data line. assumes the bench picks polarity and drive direction. */
`timescale 1ns/10ps
module sync_master_model (
  output wire       clock_pin,
  output wire       data_pin_in,
  input wire logic  data_pin_out,
  input wire logic  data_pin_oe_n,
  input wire logic  pol,
  input wire logic  drive
);
  int   half  = 200;
  logic m_bit = 1'b0;
  logic ph    = 1'b0;
  // clock rests at its polarity level between frames
  assign clock_pin = pol ^ ph;
  // an undriven line shows the inverse, never a stale value
  assign data_pin_in = !data_pin_oe_n ? data_pin_out : drive ? m_bit : ~m_bit;
  // bit changes on the drive edge, read back at the sampling edge
  task shift(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = 9'h000;
    for (int i = 0; i < n; i++) begin
      m_bit = tx[i];
      ph = 1'b1;
      #(half);
      rx[i] = data_pin_in;
      ph = 1'b0;
      #(half);
    end
  endtask
endmodule // sync_master_model

/* File: testbench/sync_serial_slave_sleep_test.sv */
/* self-checking bench for the synchronous slave serial unit.
   assumes the master model and the bound checker are compiled with it. */
`timescale 1ns/10ps
module sync_serial_slave_sleep_test;
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        sleeping = 1'b0, pol = 1'b0, drive = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00, r;
  logic [1:0]  alt_sel = 2'h0;
  logic [8:0]  got;
  wire  [7:0]  rdata;
  wire  [1:0]  pin_loc;
  wire  [11:0] vec;
  wire         ck, din, dout, oe_n, wake, irq;
  int          bad_count = 0, tests_run = 0;
  // {write, addr, write data, expected read}
  logic [23:0] rows [0:16] = '{24'h000040, 24'h010000, 24'h020000,
    24'h030010, 24'h040000, 24'h060002, 24'h070000, 24'h101050, 24'h100040,
    24'h11c0c0, 24'h110000, 24'h123030, 24'h120000, 24'h13ff10, 24'h142320,
    24'h16f1f3, 24'h160002};
  always #25 clk = ~clk;
  sync_serial_slave_sleep i_sync_serial_slave_sleep (.clk(clk), .srst(srst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sleeping(sleeping), .alternate_pin_select(alt_sel),
    .pin_location(pin_loc), .clock_pin(ck), .data_pin_in(din),
    .data_pin_out(dout), .data_pin_oe_n(oe_n), .wake(wake),
    .irq_request(irq), .irq_vector(vec));
  sync_master_model i_sync_master_model (.clock_pin(ck), .data_pin_in(din),
    .data_pin_out(dout), .data_pin_oe_n(oe_n), .pol(pol), .drive(drive));
  //////////////////////////////////////////////////////////////////////////
  task check(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  task wait_wake;
    for (int i = 0; i < 40 && wake !== 1'b1; i++) @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count++;
    end_sim;
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[k]) begin
      if (rows[k][20]) wr_reg(rows[k][18:16], rows[k][15:8]);
      rd_chk(rows[k][18:16], rows[k][7:0]);
    end
    $display("register table done");
    // nine-bit receive in sleep; single-receive enable set to be ignored
    wr_reg(3'h6, 8'h10);
    wr_reg(3'h4, 8'hf0);
    wr_reg(3'h2, 8'h20);
    wr_reg(3'h1, 8'hc0);
    @(posedge clk) sleeping <= 1'b1;
    drive = 1'b1;
    i_sync_master_model.shift(9'h1a5, 9, got);
    wait_wake;
    check({6'h0, wake, irq}, 8'h03);
    check(vec[7:0], 8'h04);
    @(posedge clk) sleeping <= 1'b0;
    rd_chk(3'h4, 8'hf1);
    rd_chk(3'h7, 8'ha5);
    rd_chk(3'h3, 8'h10);
    $display("sleep receive done");
    // third byte into a full fifo is dropped
    wr_reg(3'h4, 8'h90);
    for (int k = 1; k < 4; k++)
      i_sync_master_model.shift({1'b0, 4'(k), 4'(k)}, 8, got);
    repeat (8) @(posedge clk);
    rd_chk(3'h4, 8'h92);
    rd_chk(3'h7, 8'h11);
    rd_chk(3'h7, 8'h22);
    wr_reg(3'h4, 8'h80);
    rd_chk(3'h4, 8'h80);
    // polarity flip only while the unit is off, so no stray edge counts
    wr_reg(3'h4, 8'h00);
    pol = 1'b1;
    wr_reg(3'h0, 8'h10);
    wr_reg(3'h4, 8'h90);
    i_sync_master_model.shift(9'h05a, 8, got);
    repeat (8) @(posedge clk);
    rd_chk(3'h7, 8'h5a);
    $display("overrun and polarity done");
    wr_reg(3'h4, 8'h00);
    wr_reg(3'h0, 8'h00);
    pol = 1'b0;
    drive = 1'b0;
    wr_reg(3'h6, 8'h30);
    wr_reg(3'h4, 8'h80);
    wr_reg(3'h2, 8'h10);
    wr_reg(3'h1, 8'h40);
    wr_reg(3'h5, 8'h3c);
    wr_reg(3'h5, 8'hc3);
    rd_chk(3'h3, 8'h00);
    @(posedge clk) sleeping <= 1'b1;
    #1 check({7'h0, oe_n}, 8'h00);
    i_sync_master_model.shift(9'h000, 9, got);
    check(got[7:0], 8'h3c);
    wait_wake;
    check({6'h0, wake, irq}, 8'h02);
    @(posedge clk) sleeping <= 1'b0;
    rd_chk(3'h3, 8'h10);
    wr_reg(3'h5, 8'h99);
    rd_chk(3'h3, 8'h00);
    $display("sleep transmit done");
    @(posedge clk) alt_sel <= 2'h2;
    repeat (2) @(posedge clk);
    #1 check({6'h0, pin_loc}, 8'h02);
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    #1 check({7'h0, oe_n}, 8'h01);
    rd_chk(3'h4, 8'h00);
    $display("pins and reset done");
    end_sim;
  end
endmodule // sync_serial_slave_sleep_test

/* File: testbench/sync_slave_asserts.sv */
/* port checker for the synchronous slave serial unit.
   assumes it is bound onto the top module and sees only its ports. */
`timescale 1ns/10ps
module sync_slave_asserts (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [2:0]  addr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        sleeping,
  input wire logic [1:0]  alternate_pin_select,
  input wire logic [1:0]  pin_location,
  input wire logic        clock_pin,
  input wire logic        data_pin_out,
  input wire logic        data_pin_oe_n,
  input wire logic        wake,
  input wire logic        irq_request,
  input wire logic [11:0] irq_vector
);
  logic       ck_q;
  logic [3:0] since;
  // cycles since the master's clock moved; saturates so it never wraps
  always @(posedge clk) begin
    ck_q <= clock_pin;
    if (srst || ck_q != clock_pin) since <= 4'h0;
    else if (since != 4'hf) since <= since + 4'h1;
  end
  //////////////////////////////////////////////////////////////////////////
  chk_rdata_idle: assert property (@(posedge clk) disable iff (srst)
    !$past(rd) |-> rdata == 8'h00) else $error("read data outside slot");
  chk_vector_fixed: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> irq_vector == 12'h004) else $error("bad vector");
  chk_wake_asleep: assert property (@(posedge clk) disable iff (srst)
    wake |-> $past(sleeping)) else $error("wake while awake");
  chk_reset_quiet: assert property (@(posedge clk) disable iff (srst)
    $past(srst) |-> data_pin_oe_n && !wake && !irq_request)
    else $error("outputs active after reset");
  chk_pin_follow: assert property (@(posedge clk) disable iff (srst)
    $changed(alternate_pin_select) |=>
    pin_location == $past(alternate_pin_select)) else $error("pin select");
  chk_wake_irq: assert property (@(posedge clk) disable iff (srst)
    irq_request && $past(sleeping) |-> wake) else $error("request no wake");
  // tx bits may only move shortly after a master clock edge
  chk_tx_on_clock: assert property (@(posedge clk) disable iff (srst)
    $changed(data_pin_out) && !data_pin_oe_n && !$past(data_pin_oe_n)
    |-> since <= 4'h8) else $error("data moved without clock");
  chk_flags_unused: assert property (@(posedge clk) disable iff (srst)
    $past(rd) && $past(addr) == 3'h3 |->
    rdata[7:6] == 2'h0 && rdata[3:0] == 4'h0) else $error("flag bits");
endmodule // sync_slave_asserts

bind sync_serial_slave_sleep sync_slave_asserts i_sync_slave_asserts (
  .clk(clk), .srst(srst), .addr(addr), .rd(rd), .rdata(rdata),
  .sleeping(sleeping), .alternate_pin_select(alternate_pin_select),
  .pin_location(pin_location), .clock_pin(clock_pin),
  .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n),
  .wake(wake), .irq_request(irq_request), .irq_vector(irq_vector));
